// ### pkg/pmx_pkg.sv
// types shared by the pin routing block
package pmx_pkg;
  // effective routing selections driven to the pad multiplexers
  typedef struct packed {
    logic third_spi_pin_swap;
    logic debug_port_on;
    logic debug_port_reset_pin_on;
    logic second_can_pin_swap;
    logic timer_channel_calib_route;
    logic osc_pins_as_port_d;
    logic [1:0] first_can_pin_swap;
    logic fourth_timer_pin_swap;
    logic [1:0] third_timer_pin_swap;
    logic [1:0] second_timer_pin_swap;
    logic [1:0] first_timer_pin_swap;
    logic [1:0] third_serial_pin_swap;
    logic second_serial_pin_swap;
    logic first_serial_pin_swap;
    logic first_twowire_pin_swap;
    logic first_spi_pin_swap;
    logic memctl_addr_valid_release;
  } pmx_route_t;

  // whole state of the block
  typedef struct packed {
    logic [31:0] cfg_a;
    logic [2:0] debug_pin_config;
    logic [15:0][3:0] irq_line_source_field;
    logic memctl_rel;
    logic ph_wr;
    logic ph_word;
    logic [7:0] ph_ofs;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    pmx_route_t route;
    logic [4:0][15:0] pin_s1;
    logic [4:0][15:0] pin_s2;
    logic osc_s1;
    logic osc_s2;
    logic [15:0] line_lvl;
    logic calib_in;
  } pmx_state_t;
endpackage

// ### pkg/pmx_regs.svh
// register offsets, field positions, masks and codes of the pin routing block
`ifndef PMX_REGS_SVH
`define PMX_REGS_SVH
`define PMX_OFS_W 8
`define PMX_OFS_CFG_A 8'h04
`define PMX_OFS_SEL_0 8'h08
`define PMX_OFS_SEL_1 8'h0C
`define PMX_OFS_SEL_2 8'h10
`define PMX_OFS_SEL_3 8'h14
`define PMX_OFS_CFG_B 8'h1C
`define PMX_RST_WORD 32'h00000000
`define PMX_MASK_CFG_A 32'h1041FFFF
`define PMX_MASK_SEL 32'h0000FFFF
`define PMX_HSIZE_WORD 3'h2
`define PMX_SPI3_BIT 28
`define PMX_DBG_HI 26
`define PMX_DBG_LO 24
`define PMX_CAN2_BIT 22
`define PMX_TCAL_BIT 16
`define PMX_OSCD_BIT 15
`define PMX_CAN1_HI 14
`define PMX_CAN1_LO 13
`define PMX_TIM4_BIT 12
`define PMX_TIM3_HI 11
`define PMX_TIM3_LO 10
`define PMX_TIM2_HI 9
`define PMX_TIM2_LO 8
`define PMX_TIM1_HI 7
`define PMX_TIM1_LO 6
`define PMX_SER3_HI 5
`define PMX_SER3_LO 4
`define PMX_SER2_BIT 3
`define PMX_SER1_BIT 2
`define PMX_TWI_BIT 1
`define PMX_SPI1_BIT 0
`define PMX_MEMCTL_BIT 10
`define PMX_DBG_FULL 3'h0
`define PMX_DBG_NO_RST 3'h1
`define PMX_DBG_OFF 3'h2
`define PMX_CODE_DEF 2'h0
`define PMX_CODE_01 2'h1
`define PMX_CODE_10 2'h2
`define PMX_SRC_LAST 4'h4
`define PMX_SRC_DEF 4'h0
`define PMX_CALIB_PIN 3
`endif

// ### testbench/pmx_pin_route_bench.sv
// self-checking bench for the pin routing and line source block
`timescale 1ns/1ps
`include "pmx_regs.svh"
module pmx_pin_route_bench;
  import pmx_pkg::*;
  logic core_clk, rst_n, clk_en, hsel, hwrite, low_speed_internal_osc;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, rd, hrdata;
  logic hreadyout, hresp, timer_calib_input;
  logic [4:0][15:0] pins;
  logic [15:0] irq_line_level, el;
  pmx_route_t route, er;
  int miscompares, comparisons;

  // single slave: hready loops back from hreadyout
  pmx_pin_route DUT (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .port_pin_in(pins), .low_speed_internal_osc(low_speed_internal_osc), .route(route),
    .irq_line_level(irq_line_level), .timer_calib_input(timer_calib_input));

  // 10 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one single transfer: address phase, then data phase, each held until hready
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [2:0] sz,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= sz;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    q = hrdata;
    chk({31'h0, hresp}, 32'h0);
    @(negedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, `PMX_HSIZE_WORD, d, rd);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, `PMX_HSIZE_WORD, 32'h0, rd);
    chk(rd, exp);
  endtask

  // expected route with everything at default
  task automatic route_def();
    er = '0;
    er.debug_port_on = 1'b1;
    er.debug_port_reset_pin_on = 1'b1;
  endtask

  // reset values of every register and of the routing outputs
  task automatic t_reset();
    logic [7:0] ofs [6] = '{`PMX_OFS_CFG_A, `PMX_OFS_SEL_0, `PMX_OFS_SEL_1,
      `PMX_OFS_SEL_2, `PMX_OFS_SEL_3, `PMX_OFS_CFG_B};
    route_def();
    chk({10'h0, route}, {10'h0, er});
    chk({31'h0, hreadyout}, 32'h1);
    for (int i = 0; i < 6; i++) rdchk(ofs[i], `PMX_RST_WORD);
    $display("test reset done");
  endtask

  // every swap field, every two-bit code and every debug code
  task automatic t_cfg_a();
    logic [1:0] c;
    wr(`PMX_OFS_CFG_A, 32'hFFFFFFFF);
    rdchk(`PMX_OFS_CFG_A, `PMX_MASK_CFG_A);
    er = '1;
    er.memctl_addr_valid_release = 1'b0;
    chk({10'h0, route}, {10'h0, er});
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      wr(`PMX_OFS_CFG_A, (32'(c) << 13) | (32'(c) << 10) | (32'(c) << 8) |
        (32'(c) << 6) | (32'(c) << 4));
      route_def();
      er.first_can_pin_swap = (c == 2'h1) ? 2'h0 : c;
      er.third_timer_pin_swap = (c == 2'h1) ? 2'h0 : c;
      er.second_timer_pin_swap = c;
      er.first_timer_pin_swap = (c == 2'h2) ? 2'h0 : c;
      er.third_serial_pin_swap = (c == 2'h2) ? 2'h0 : c;
      chk({10'h0, route}, {10'h0, er});
    end
    for (int d = 0; d < 8; d++) begin
      wr(`PMX_OFS_CFG_A, 32'(d) << 24);
      rdchk(`PMX_OFS_CFG_A, 32'h0);
      chk({30'h0, route.debug_port_on, route.debug_port_reset_pin_on},
        {30'h0, d != 2, d != 1 && d != 2});
    end
    $display("test cfg_a done");
  endtask

  // second config register, a non-word write and unmapped places
  task automatic t_cfg_b();
    wr(`PMX_OFS_CFG_B, 32'hFFFFFFFF);
    rdchk(`PMX_OFS_CFG_B, 32'h00000400);
    chk({31'h0, route.memctl_addr_valid_release}, 32'h1);
    ahb(1'b1, `PMX_OFS_CFG_B, 3'h0, 32'h0, rd);
    rdchk(`PMX_OFS_CFG_B, 32'h00000400);
    wr(8'h18, 32'hFFFFFFFF);
    rdchk(8'h18, 32'h0);
    rdchk(8'h00, 32'h0);
    $display("test cfg_b done");
  endtask

  // each line walks through all five ports; then a reserved code
  task automatic t_lines();
    logic [31:0] v;
    @(posedge core_clk);
    for (int q = 0; q < 5; q++) pins[q] <= 16'h1357 * 16'(q + 1);
    for (int p = 0; p < 5; p++) begin
      for (int r = 0; r < 4; r++) begin
        v = '0;
        for (int k = 0; k < 4; k++) v[4*k +: 4] = 4'((4 * r + k + p) % 5);
        wr(`PMX_OFS_SEL_0 + 8'(4 * r), v);
        rdchk(`PMX_OFS_SEL_0 + 8'(4 * r), v);
      end
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      for (int n = 0; n < 16; n++) el[n] = pins[(n + p) % 5][n];
      chk({16'h0, irq_line_level}, {16'h0, el});
    end
    wr(`PMX_OFS_SEL_0, 32'hFFFFFFFF);
    rdchk(`PMX_OFS_SEL_0, `PMX_MASK_SEL);
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    chk({28'h0, irq_line_level[3:0]}, {28'h0, pins[0][3:0]});
    $display("test lines done");
  endtask

  // timer channel input: pin A3, then the internal oscillator
  task automatic t_calib();
    wr(`PMX_OFS_CFG_A, 32'h0);
    @(posedge core_clk);
    pins[0][`PMX_CALIB_PIN] <= 1'b1;
    low_speed_internal_osc <= 1'b0;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    chk({31'h0, timer_calib_input}, 32'h1);
    wr(`PMX_OFS_CFG_A, 32'h1 << `PMX_TCAL_BIT);
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk({31'h0, timer_calib_input}, 32'h0);
    @(posedge core_clk);
    low_speed_internal_osc <= 1'b1;
    pins[0][`PMX_CALIB_PIN] <= 1'b0;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    chk({31'h0, timer_calib_input}, 32'h1);
    $display("test calib done");
  endtask

  // clock enable low freezes the line levels; a reset in mid-run restores defaults
  task automatic t_hold();
    for (int n = 0; n < 16; n++) el[n] = pins[(n < 4) ? 0 : (n + 4) % 5][n];
    chk({16'h0, irq_line_level}, {16'h0, el});
    @(posedge core_clk);
    clk_en <= 1'b0;
    @(posedge core_clk);
    pins <= ~pins;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    chk({16'h0, irq_line_level}, {16'h0, el});
    @(posedge core_clk);
    clk_en <= 1'b1;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    for (int n = 0; n < 16; n++) el[n] = pins[(n < 4) ? 0 : (n + 4) % 5][n];
    chk({16'h0, irq_line_level}, {16'h0, el});
    wr(`PMX_OFS_CFG_A, {5'h0, `PMX_DBG_OFF, 24'h00FFFF});
    chk({31'h0, route.debug_port_on}, 32'h0);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    route_def();
    chk({10'h0, route}, {10'h0, er});
    rdchk(`PMX_OFS_CFG_A, `PMX_RST_WORD);
    rdchk(`PMX_OFS_SEL_3, `PMX_RST_WORD);
    $display("test hold done");
  endtask

  // verdict and end of run
  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run length
  initial begin
    #1000000;
    miscompares++;
    complete_run();
  end

  // main sequence
  initial begin
    miscompares = 0;
    comparisons = 0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = `PMX_HSIZE_WORD;
    hwdata = 32'h0;
    pins = '0;
    low_speed_internal_osc = 1'b0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    t_reset();
    t_cfg_a();
    t_cfg_b();
    t_lines();
    t_calib();
    t_hold();
    complete_run();
  end
endmodule

// ### verilog/pmx_pin_route.sv
// pin routing configuration and interrupt line source selection behind an AHB-Lite slave
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`include "pmx_regs.svh"

// Operation
// RL1: third SPI swap bit picks default or alternate pins; only on larger variants.
// RL2: debug pin field is write-only; reads return zero.
// RL3: debug code 000 full port, 001 without reset pin, 010 port off.
// RL4: after reset the debug port is fully enabled.
// RL5: second CAN swap bit moves its receive and transmit pins.
// RL6: calibration route feeds timer channel from the low speed oscillator.
// RL7: oscillator pins used as port D pins 0 and 1 when set.
// RL8: first CAN field: 00 default, 10 partial, 11 full, 01 unused.
// RL9: fourth timer swap bit moves all four channels to port D.
// RL10: third timer field: 00 default, 10 partial, 11 full, 01 unused.
// RL11: second timer field uses all four codes.
// RL12: first timer field: 00 default, 01 partial, 11 full, 10 unused.
// RL13: third serial field: 00 default, 01 partial, 11 full, 10 unused.
// RL14: single swap bits for second and first serial, two-wire and SPI.
// RL15: line source codes 0 to 4 pick ports A to E; others reserved.
// RL16: four select registers, four lines each, line n at nibble n mod 4.
// RL17: software uses only full word transfers on the second config register.
// RL18: reserved bits are written with reset value and read as zero.
// RL19: memory controller address valid release bit frees the pin when set.
// RL20: unused or reserved codes keep the default pin assignment.
module pmx_pin_route
  import pmx_pkg::*;
#(
  parameter bit HAS_THIRD_SPI = 1'b1
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // port pins A..E and the oscillator
  input wire logic [4:0][15:0] port_pin_in,
  input wire logic low_speed_internal_osc,
  // routing results
  output pmx_route_t route,
  output logic [15:0] irq_line_level,
  output logic timer_calib_input
);

  pmx_state_t s_r;
  pmx_state_t s_nxt;
  logic [15:0] lvl_exp;

  // unused codes fall back to default pins
  function automatic logic [1:0] keep_def(input logic [1:0] code, input logic [1:0] unused);
    keep_def = (code == unused) ? `PMX_CODE_DEF : code; // RL20
  endfunction

  // decode stored configuration into pad selections
  function automatic pmx_route_t route_of(input logic [31:0] a, input logic [2:0] d,
                                          input logic m);
    pmx_route_t r;
    r = '0;
    r.third_spi_pin_swap = a[`PMX_SPI3_BIT] & HAS_THIRD_SPI; // RL1
    r.debug_port_on = 1'b1; // RL3
    r.debug_port_reset_pin_on = 1'b1;
    if (d == `PMX_DBG_NO_RST) begin
      r.debug_port_reset_pin_on = 1'b0; // RL3
    end else if (d == `PMX_DBG_OFF) begin
      r.debug_port_on = 1'b0; // RL3
      r.debug_port_reset_pin_on = 1'b0;
    end
    r.second_can_pin_swap = a[`PMX_CAN2_BIT]; // RL5
    r.timer_channel_calib_route = a[`PMX_TCAL_BIT]; // RL6
    r.osc_pins_as_port_d = a[`PMX_OSCD_BIT]; // RL7
    r.first_can_pin_swap = keep_def(a[`PMX_CAN1_HI:`PMX_CAN1_LO], `PMX_CODE_01); // RL8
    r.fourth_timer_pin_swap = a[`PMX_TIM4_BIT]; // RL9
    r.third_timer_pin_swap = keep_def(a[`PMX_TIM3_HI:`PMX_TIM3_LO], `PMX_CODE_01); // RL10
    r.second_timer_pin_swap = a[`PMX_TIM2_HI:`PMX_TIM2_LO]; // RL11
    r.first_timer_pin_swap = keep_def(a[`PMX_TIM1_HI:`PMX_TIM1_LO], `PMX_CODE_10); // RL12
    r.third_serial_pin_swap = keep_def(a[`PMX_SER3_HI:`PMX_SER3_LO], `PMX_CODE_10); // RL13
    r.second_serial_pin_swap = a[`PMX_SER2_BIT]; // RL14
    r.first_serial_pin_swap = a[`PMX_SER1_BIT];
    r.first_twowire_pin_swap = a[`PMX_TWI_BIT];
    r.first_spi_pin_swap = a[`PMX_SPI1_BIT];
    r.memctl_addr_valid_release = m; // RL19
    return r;
  endfunction

  // read word for one offset; reserved and write-only bits read zero
  function automatic logic [31:0] read_word(input pmx_state_t st, input logic [7:0] ofs);
    logic [31:0] w;
    w = `PMX_RST_WORD;
    case (ofs)
      `PMX_OFS_CFG_A: w = st.cfg_a & `PMX_MASK_CFG_A; // RL2 RL18
      `PMX_OFS_SEL_0: w[15:0] = st.irq_line_source_field[3:0]; // RL16
      `PMX_OFS_SEL_1: w[15:0] = st.irq_line_source_field[7:4];
      `PMX_OFS_SEL_2: w[15:0] = st.irq_line_source_field[11:8];
      `PMX_OFS_SEL_3: w[15:0] = st.irq_line_source_field[15:12];
      `PMX_OFS_CFG_B: w[`PMX_MEMCTL_BIT] = st.memctl_rel;
      default: w = `PMX_RST_WORD;
    endcase
    return w;
  endfunction

  // expected line levels from the synchronised pins; reserved codes act as port A
  always_comb begin
    lvl_exp = '0;
    for (int n = 0; n < 16; n++) begin
      if (s_r.irq_line_source_field[n] <= `PMX_SRC_LAST) begin
        lvl_exp[n] = s_r.pin_s2[s_r.irq_line_source_field[n][2:0]][n]; // RL15
      end else begin
        lvl_exp[n] = s_r.pin_s2[`PMX_SRC_DEF][n]; // RL20
      end
    end
  end

  // next state: synchronisers, bus data phase, bus address phase, routing
  always_comb begin
    s_nxt = s_r;
    s_nxt.pin_s1 = port_pin_in;
    s_nxt.pin_s2 = s_r.pin_s1;
    s_nxt.osc_s1 = low_speed_internal_osc;
    s_nxt.osc_s2 = s_r.osc_s1;
    s_nxt.hreadyout = 1'b1;
    s_nxt.hresp = 1'b0;
    // data phase write; partial-word writes are dropped
    if (s_r.ph_wr && s_r.ph_word) begin // RL17
      case (s_r.ph_ofs)
        `PMX_OFS_CFG_A: begin
          s_nxt.cfg_a = hwdata & `PMX_MASK_CFG_A; // RL18
          s_nxt.debug_pin_config = hwdata[`PMX_DBG_HI:`PMX_DBG_LO]; // RL2
        end
        `PMX_OFS_SEL_0: s_nxt.irq_line_source_field[3:0] = hwdata[15:0]; // RL16
        `PMX_OFS_SEL_1: s_nxt.irq_line_source_field[7:4] = hwdata[15:0];
        `PMX_OFS_SEL_2: s_nxt.irq_line_source_field[11:8] = hwdata[15:0];
        `PMX_OFS_SEL_3: s_nxt.irq_line_source_field[15:12] = hwdata[15:0];
        `PMX_OFS_CFG_B: s_nxt.memctl_rel = hwdata[`PMX_MEMCTL_BIT]; // RL19
        default: s_nxt.ph_wr = 1'b0;
      endcase
    end
    // address phase; read data sees a write finishing in the same cycle
    s_nxt.ph_wr = 1'b0;
    if (hsel && htrans[1] && hready) begin
      s_nxt.ph_wr = hwrite;
      s_nxt.ph_word = (hsize == `PMX_HSIZE_WORD);
      s_nxt.ph_ofs = haddr[7:0];
      if (!hwrite) begin
        s_nxt.hrdata = read_word(s_nxt, haddr[7:0]);
      end
    end
    // routing outputs follow the registers in the same edge
    s_nxt.route = route_of(s_nxt.cfg_a, s_nxt.debug_pin_config, s_nxt.memctl_rel);
    s_nxt.line_lvl = lvl_exp;
    // calibration input taken from the oscillator or the channel pin
    if (s_r.route.timer_channel_calib_route) begin
      s_nxt.calib_in = s_r.osc_s2; // RL6
    end else begin
      s_nxt.calib_in = s_r.pin_s2[`PMX_SRC_DEF][`PMX_CALIB_PIN];
    end
  end

  // state register; clock enable low freezes everything
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.hreadyout <= 1'b1;
      s_r.route.debug_port_on <= 1'b1; // RL4
      s_r.route.debug_port_reset_pin_on <= 1'b1; // RL4
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign hreadyout = s_r.hreadyout;
  assign hresp = s_r.hresp;
  assign hrdata = s_r.hrdata;
  assign route = s_r.route;
  assign irq_line_level = s_r.line_lvl;
  assign timer_calib_input = s_r.calib_in;

  // data phase writes to the two config registers and to select registers 0 and 3
  sequence s_wr_a;
    clk_en && s_r.ph_wr && s_r.ph_word && (s_r.ph_ofs == `PMX_OFS_CFG_A);
  endsequence

  sequence s_wr_b;
    clk_en && s_r.ph_wr && s_r.ph_word && (s_r.ph_ofs == `PMX_OFS_CFG_B);
  endsequence

  sequence s_wr_sel3;
    clk_en && s_r.ph_wr && s_r.ph_word && (s_r.ph_ofs == `PMX_OFS_SEL_3);
  endsequence

  sequence s_wr_sel0;
    clk_en && s_r.ph_wr && s_r.ph_word && (s_r.ph_ofs == `PMX_OFS_SEL_0);
  endsequence

  // read address phase aimed at one of the line select registers
  sequence s_rd_sel;
    clk_en && hsel && htrans[1] && hready && !hwrite && (haddr[7:0] >= `PMX_OFS_SEL_0) &&
      (haddr[7:0] <= `PMX_OFS_SEL_3);
  endsequence

  property p_dbg_reset_full;
    @(posedge core_clk) $rose(rst_n) |-> route.debug_port_on && route.debug_port_reset_pin_on;
  endproperty
  a_dbg_reset_full: assert property (p_dbg_reset_full) else $error("debug port off after reset"); // RL4

  property p_dbg_read_zero;
    @(posedge core_clk) disable iff (!rst_n)
      (clk_en && hsel && htrans[1] && hready && !hwrite && haddr[7:0] == `PMX_OFS_CFG_A)
      |=> hrdata[`PMX_DBG_HI:`PMX_DBG_LO] == 3'h0 && hrdata[31:29] == 3'h0;
  endproperty
  a_dbg_read_zero: assert property (p_dbg_read_zero) else $error("write-only bits read back"); // RL2

  property p_dbg_no_rst;
    @(posedge core_clk) disable iff (!rst_n)
      s_wr_a ##0 (hwdata[`PMX_DBG_HI:`PMX_DBG_LO] == `PMX_DBG_NO_RST)
      |=> route.debug_port_on && !route.debug_port_reset_pin_on;
  endproperty
  a_dbg_no_rst: assert property (p_dbg_no_rst) else $error("debug code 001 wrong"); // RL3

  property p_dbg_off;
    @(posedge core_clk) disable iff (!rst_n)
      s_wr_a ##0 (hwdata[`PMX_DBG_HI:`PMX_DBG_LO] == `PMX_DBG_OFF) |=> !route.debug_port_on;
  endproperty
  a_dbg_off: assert property (p_dbg_off) else $error("debug code 010 wrong"); // RL3

  property p_can1_unused;
    @(posedge core_clk) disable iff (!rst_n)
      s_wr_a ##0 (hwdata[`PMX_CAN1_HI:`PMX_CAN1_LO] == `PMX_CODE_01)
      |=> route.first_can_pin_swap == `PMX_CODE_DEF;
  endproperty
  a_can1_unused: assert property (p_can1_unused) else $error("unused CAN code routed"); // RL8

  property p_tim1_unused;
    @(posedge core_clk) disable iff (!rst_n)
      s_wr_a ##0 (hwdata[`PMX_TIM1_HI:`PMX_TIM1_LO] == `PMX_CODE_10)
      |=> route.first_timer_pin_swap == `PMX_CODE_DEF;
  endproperty
  a_tim1_unused: assert property (p_tim1_unused) else $error("unused timer code routed"); // RL12

  property p_tim2_all;
    @(posedge core_clk) disable iff (!rst_n)
      s_wr_a |=> route.second_timer_pin_swap == $past(hwdata[`PMX_TIM2_HI:`PMX_TIM2_LO]);
  endproperty
  a_tim2_all: assert property (p_tim2_all) else $error("second timer code lost"); // RL11

  property p_spi1_bit;
    @(posedge core_clk) disable iff (!rst_n)
      s_wr_a |=> route.first_spi_pin_swap == $past(hwdata[`PMX_SPI1_BIT]);
  endproperty
  a_spi1_bit: assert property (p_spi1_bit) else $error("first SPI swap not applied"); // RL14

  property p_sel3_line15;
    @(posedge core_clk) disable iff (!rst_n)
      s_wr_sel3 |=> s_r.irq_line_source_field[15] == $past(hwdata[15:12]);
  endproperty
  a_sel3_line15: assert property (p_sel3_line15) else $error("line 15 nibble misplaced"); // RL16

  property p_line_level;
    @(posedge core_clk) disable iff (!rst_n)
      clk_en |=> irq_line_level == $past(lvl_exp);
  endproperty
  a_line_level: assert property (p_line_level) else $error("line level not from source"); // RL15

  property p_calib;
    @(posedge core_clk) disable iff (!rst_n)
      (clk_en && s_r.route.timer_channel_calib_route) |=> timer_calib_input == $past(s_r.osc_s2);
  endproperty
  a_calib: assert property (p_calib) else $error("calibration input not oscillator"); // RL6

  property p_memctl;
    @(posedge core_clk) disable iff (!rst_n)
      s_wr_b |=> route.memctl_addr_valid_release == $past(hwdata[`PMX_MEMCTL_BIT]);
  endproperty
  a_memctl: assert property (p_memctl) else $error("address valid release not applied"); // RL19

  property p_part_word;
    @(posedge core_clk) disable iff (!rst_n)
      (clk_en && s_r.ph_wr && !s_r.ph_word) |=> $stable(route) && $stable(s_r.cfg_a);
  endproperty
  a_part_word: assert property (p_part_word) else $error("partial write changed config"); // RL17

  property p_spi3_variant;
    @(posedge core_clk) disable iff (!rst_n)
      s_wr_a |=> route.third_spi_pin_swap == (HAS_THIRD_SPI && $past(hwdata[`PMX_SPI3_BIT]));
  endproperty
  a_spi3_variant: assert property (p_spi3_variant) else $error("third SPI swap wrong"); // RL1

  property p_dbg_full;
    @(posedge core_clk) disable iff (!rst_n)
      s_wr_a ##0 (hwdata[`PMX_DBG_HI:`PMX_DBG_LO] == `PMX_DBG_FULL)
      |=> route.debug_port_on && route.debug_port_reset_pin_on;
  endproperty
  a_dbg_full: assert property (p_dbg_full) else $error("debug code 000 wrong"); // RL3

  property p_can2_bit;
    @(posedge core_clk) disable iff (!rst_n)
      s_wr_a |=> route.second_can_pin_swap == $past(hwdata[`PMX_CAN2_BIT]);
  endproperty
  a_can2_bit: assert property (p_can2_bit) else $error("second CAN swap not applied"); // RL5

  property p_oscd_bit;
    @(posedge core_clk) disable iff (!rst_n)
      s_wr_a |=> route.osc_pins_as_port_d == $past(hwdata[`PMX_OSCD_BIT]);
  endproperty
  a_oscd_bit: assert property (p_oscd_bit) else $error("oscillator pins not reused"); // RL7

  property p_tim4_bit;
    @(posedge core_clk) disable iff (!rst_n)
      s_wr_a |=> route.fourth_timer_pin_swap == $past(hwdata[`PMX_TIM4_BIT]);
  endproperty
  a_tim4_bit: assert property (p_tim4_bit) else $error("fourth timer swap not applied"); // RL9

  property p_tim3_unused;
    @(posedge core_clk) disable iff (!rst_n)
      s_wr_a ##0 (hwdata[`PMX_TIM3_HI:`PMX_TIM3_LO] == `PMX_CODE_01)
      |=> route.third_timer_pin_swap == `PMX_CODE_DEF;
  endproperty
  a_tim3_unused: assert property (p_tim3_unused) else $error("unused timer code routed"); // RL10

  property p_ser3_unused;
    @(posedge core_clk) disable iff (!rst_n)
      s_wr_a ##0 (hwdata[`PMX_SER3_HI:`PMX_SER3_LO] == `PMX_CODE_10)
      |=> route.third_serial_pin_swap == `PMX_CODE_DEF;
  endproperty
  a_ser3_unused: assert property (p_ser3_unused) else $error("unused serial code routed"); // RL13

  property p_ser2_bit;
    @(posedge core_clk) disable iff (!rst_n)
      s_wr_a |=> route.second_serial_pin_swap == $past(hwdata[`PMX_SER2_BIT]);
  endproperty
  a_ser2_bit: assert property (p_ser2_bit) else $error("second serial swap not applied"); // RL14

  property p_ser1_bit;
    @(posedge core_clk) disable iff (!rst_n)
      s_wr_a |=> route.first_serial_pin_swap == $past(hwdata[`PMX_SER1_BIT]);
  endproperty
  a_ser1_bit: assert property (p_ser1_bit) else $error("first serial swap not applied"); // RL14

  property p_twi_bit;
    @(posedge core_clk) disable iff (!rst_n)
      s_wr_a |=> route.first_twowire_pin_swap == $past(hwdata[`PMX_TWI_BIT]);
  endproperty
  a_twi_bit: assert property (p_twi_bit) else $error("two-wire swap not applied"); // RL14

  property p_sel0_line0;
    @(posedge core_clk) disable iff (!rst_n)
      s_wr_sel0 |=> s_r.irq_line_source_field[0] == $past(hwdata[3:0]);
  endproperty
  a_sel0_line0: assert property (p_sel0_line0) else $error("line 0 nibble misplaced"); // RL16

  property p_rd_sel_rsvd;
    @(posedge core_clk) disable iff (!rst_n)
      s_rd_sel |=> (hrdata & ~`PMX_MASK_SEL) == `PMX_RST_WORD;
  endproperty
  a_rd_sel_rsvd: assert property (p_rd_sel_rsvd) else $error("reserved select bits set"); // RL18

  property p_calib_pin;
    @(posedge core_clk) disable iff (!rst_n)
      (clk_en && !s_r.route.timer_channel_calib_route)
      |=> timer_calib_input == $past(s_r.pin_s2[`PMX_SRC_DEF][`PMX_CALIB_PIN]);
  endproperty
  a_calib_pin: assert property (p_calib_pin) else $error("calibration input not pin"); // RL6

  property p_line_reserved;
    @(posedge core_clk) disable iff (!rst_n)
      (clk_en && s_r.irq_line_source_field[0] > `PMX_SRC_LAST)
      |=> irq_line_level[0] == $past(s_r.pin_s2[`PMX_SRC_DEF][0]);
  endproperty
  a_line_reserved: assert property (p_line_reserved) else $error("reserved code not port A"); // RL20

  property p_okay;
    @(posedge core_clk) disable iff (!rst_n)
      !hresp && hreadyout;
  endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready and okay"); // RL17

endmodule
